// ===== verilog/acrp_pkg.sv
// Purpose: Shared constants for the converter configuration register slice.
// Assumes: Serial frames of 32 bits, MSB first: 7-bit command, 9-bit address, 16-bit data.
// Notes: Register offsets are byte addresses; each register spans four bytes.
package acrp_pkg;
    // Register byte offsets.
    localparam logic [8:0] ACRP_OFS_CHAIN_IDENTITY = 9'h000;
    localparam logic [8:0] ACRP_OFS_RESET_POWER = 9'h004;
    localparam logic [8:0] ACRP_OFS_SERIAL_INPUT = 9'h008;
    // Register index is the byte address without its two lane bits.
    localparam logic [6:0] ACRP_IDX_CHAIN_IDENTITY = ACRP_OFS_CHAIN_IDENTITY[8:2];
    localparam logic [6:0] ACRP_IDX_RESET_POWER = ACRP_OFS_RESET_POWER[8:2];
    localparam logic [6:0] ACRP_IDX_SERIAL_INPUT = ACRP_OFS_SERIAL_INPUT[8:2];
    // Field positions.
    localparam int ACRP_CHAIN_ID_LSB = 16;
    localparam int ACRP_KEY_LSB = 8;
    localparam int ACRP_SUPPLY_AL_BIT = 5;
    localparam int ACRP_INPUT_AL_BIT = 4;
    localparam int ACRP_PIN_KIND_BIT = 2;
    localparam int ACRP_LIGHT_BIT = 1;
    localparam int ACRP_DEEP_BIT = 0;
    localparam int ACRP_FRAME_KIND_LSB = 0;
    // Byte lanes holding the writable fields.
    localparam logic [1:0] ACRP_LANE_CHAIN_ID = 2'h2;
    localparam logic [1:0] ACRP_LANE_KEY = 2'h1;
    localparam logic [1:0] ACRP_LANE_CTRL = 2'h0;
    localparam logic [1:0] ACRP_LANE_FRAME = 2'h0;
    // Unlock key value and reset values.
    localparam logic [7:0] ACRP_UNLOCK_VALUE = 8'h69;
    localparam logic [7:0] ACRP_KEY_RESET = 8'h00;
    localparam logic [3:0] ACRP_CHAIN_ID_RESET = 4'h0;
    localparam logic [1:0] ACRP_FRAME_KIND_RESET = 2'h0;
    localparam logic ACRP_BIT_RESET = 1'b0;
    // Serial frame layout.
    localparam int ACRP_FRAME_BITS = 32;
    localparam logic [5:0] ACRP_FRAME_BITS_C = 6'h20;
    localparam logic [6:0] ACRP_CMD_WRITE_HALF = 7'h68;
    localparam logic [6:0] ACRP_CMD_WRITE_BYTE = 7'h69;
    localparam logic [6:0] ACRP_CMD_READ_HALF = 7'h64;
    localparam logic [6:0] ACRP_CMD_NOP = 7'h00;
    // Frame tracking states.
    typedef enum logic [0:0] {ACRP_FR_IDLE, ACRP_FR_SHIFT} acrp_frame_e;
endpackage : acrp_pkg

// ===== verilog/acrp_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin.
// Assumes: The pin is asynchronous to ref_clk.
// Notes: The output changes only when stages two and three agree.
`timescale 1ns/1ns
module acrp_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    logic meta_q;
    logic mid_q;
    logic late_q;
    logic level_q;
    logic level_d;

    // Stage one feeds stage two only, so metastability never reaches a gate.
    always_comb
    begin
        level_d = level_q;
        if (mid_q == late_q)
        begin
            level_d = late_q;
        end
    end

    // Plain shift chain plus the filtered level.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            meta_q <= RESET_VALUE;
            mid_q <= RESET_VALUE;
            late_q <= RESET_VALUE;
            level_q <= RESET_VALUE;
        end
        else
        begin
            meta_q <= pin;
            mid_q <= meta_q;
            late_q <= mid_q;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule : acrp_sync

// ===== verilog/acrp_regs.sv
// Purpose: Configuration, reset and power registers behind the serial port.
// Assumes: The serial clock is slow enough to be oversampled by ref_clk.
// Notes: Reset pin and frame pins are filtered by acrp_sync before use.
`timescale 1ns/1ns
// What this block does
// R01 - Four-bit chain identity field, bits 19-16.
// R02 - Reserved bits read zero, ignore writes.
// R03 - Host writes key 69h to 05h first.
// R04 - Key field gates control bits 5-0.
// R05 - Bit 5 disables the supply alarm.
// R06 - Bit 4 disables the input alarm.
// R07 - Bit 2 selects reset pin kind.
// R08 - Pin kind sticks until power cycle.
// R09 - Bit 1 allows light sleep.
// R10 - Bit 0 requests deep sleep.
// R11 - Frame kind selects SPI mode, both directions.
// R12 - Power-on-only fields survive application reset.
// R13 - Little-endian byte lanes per register.
// R14 - Host changes frame kind using mode 0; the bench also changes it in modes 1-3, and the block accepts those writes.
// R15 - Writes need 32 serial clocks.
// R16 - Locked or reserved writes silently ignored.
module acrp_regs
    import acrp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic reset_pin_n,
    input wire logic convert_select_pin,
    input wire logic conversion_busy,
    output logic sdo,
    output logic sdo_en,
    output logic [3:0] chain_identity,
    output logic supply_alarm_off,
    output logic input_alarm_off,
    output logic reset_pin_kind,
    output logic light_sleep_allow,
    output logic deep_sleep_request,
    output logic [1:0] serial_frame_kind,
    output logic light_sleep_state
);
    // Filtered pin levels.
    logic sclk_s;
    logic cs_n_s;
    logic sdi_s;
    logic rst_pin_s;
    logic conv_sel_s;

    acrp_sync #(.RESET_VALUE(1'b0)) u_sync_sclk (
        .ref_clk(ref_clk), .rst(rst), .pin(sclk), .level(sclk_s));
    acrp_sync #(.RESET_VALUE(1'b1)) u_sync_cs (
        .ref_clk(ref_clk), .rst(rst), .pin(cs_n), .level(cs_n_s));
    acrp_sync #(.RESET_VALUE(1'b0)) u_sync_sdi (
        .ref_clk(ref_clk), .rst(rst), .pin(sdi), .level(sdi_s));
    acrp_sync #(.RESET_VALUE(1'b1)) u_sync_rstpin (
        .ref_clk(ref_clk), .rst(rst), .pin(reset_pin_n), .level(rst_pin_s));
    acrp_sync #(.RESET_VALUE(1'b0)) u_sync_convsel (
        .ref_clk(ref_clk), .rst(rst), .pin(convert_select_pin), .level(conv_sel_s));

    // Stored fields.
    logic [3:0] chain_id_q, chain_id_d;
    logic [7:0] key_q, key_d;
    logic supply_off_q, supply_off_d;
    logic input_off_q, input_off_d;
    logic pin_kind_q, pin_kind_d;
    logic light_allow_q, light_allow_d;
    logic deep_q, deep_d;
    logic [1:0] frame_kind_q, frame_kind_d;
    logic light_state_q, light_state_d;

    // Serial engine state.
    acrp_frame_e frame_q, frame_d;
    logic sclk_prev_q, sclk_prev_d;
    logic rst_pin_prev_q, rst_pin_prev_d;
    logic [5:0] bit_cnt_q, bit_cnt_d;
    logic [31:0] rx_q, rx_d;
    logic [31:0] tx_q, tx_d;
    logic [15:0] rd_half_q, rd_half_d;
    logic sdo_q, sdo_d;
    logic sdo_en_q, sdo_en_d;

    // Edge and event decode.
    logic sclk_rise;
    logic sclk_fall;
    logic capture_edge;
    logic launch_edge;
    logic frame_start;
    logic frame_end;
    logic pin_reset_event;
    logic por_class;
    logic app_class;
    logic write_ok;
    logic [6:0] cmd;
    logic [8:0] addr;
    logic [15:0] wdata;
    logic [31:0] wword;
    logic [3:0] wlane;
    logic [31:0] rword;

    // Capture on the rising edge when CPOL equals CPHA, else on the falling edge.
    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;
    assign capture_edge = (frame_kind_q[1] == frame_kind_q[0]) ? sclk_rise : sclk_fall; // see R11
    assign launch_edge = (frame_kind_q[1] == frame_kind_q[0]) ? sclk_fall : sclk_rise; // see R11
    assign frame_start = (frame_q == ACRP_FR_IDLE) & ~cs_n_s;
    assign frame_end = (frame_q == ACRP_FR_SHIFT) & cs_n_s;

    // A pin reset is taken on the filtered falling edge of the active-low pin.
    assign pin_reset_event = ~rst_pin_s & rst_pin_prev_q;
    assign por_class = pin_reset_event & ~pin_kind_q; // see R07
    assign app_class = pin_reset_event & pin_kind_q; // see R07, R08

    // Short frames are dropped: a write counts only after 32 captured bits.
    assign write_ok = frame_end & (bit_cnt_q == ACRP_FRAME_BITS_C); // see R15
    assign cmd = rx_q[31:25];
    assign addr = rx_q[24:16];
    assign wdata = rx_q[15:0];

    // Byte lanes of the addressed register, lowest lane at the base address.
    always_comb
    begin
        wword = 32'h0000_0000;
        wlane = 4'h0;
        if (write_ok && cmd == ACRP_CMD_WRITE_BYTE)
        begin
            wword = {4{wdata[7:0]}};
            wlane = 4'h1 << addr[1:0]; // see R13
        end
        else if (write_ok && cmd == ACRP_CMD_WRITE_HALF)
        begin
            wword = {2{wdata}};
            wlane = addr[1] ? 4'hC : 4'h3; // see R13
        end
    end

    // Read word assembly; every bit not named here is reserved and reads zero.
    always_comb
    begin
        rword = 32'h0000_0000; // see R02
        case (addr[8:2])
            ACRP_IDX_CHAIN_IDENTITY:
            begin
                rword[ACRP_CHAIN_ID_LSB +: 4] = chain_id_q;
            end
            ACRP_IDX_RESET_POWER:
            begin
                rword[ACRP_KEY_LSB +: 8] = key_q;
                rword[ACRP_SUPPLY_AL_BIT] = supply_off_q;
                rword[ACRP_INPUT_AL_BIT] = input_off_q;
                rword[ACRP_PIN_KIND_BIT] = pin_kind_q;
                rword[ACRP_LIGHT_BIT] = light_allow_q;
                rword[ACRP_DEEP_BIT] = deep_q;
            end
            ACRP_IDX_SERIAL_INPUT:
            begin
                rword[ACRP_FRAME_KIND_LSB +: 2] = frame_kind_q;
            end
            default:
            begin
                rword = 32'h0000_0000;
            end
        endcase
    end

    // Field updates; writes only touch named fields so reserved bits stay zero.
    always_comb
    begin
        chain_id_d = chain_id_q;
        key_d = key_q;
        supply_off_d = supply_off_q;
        input_off_d = input_off_q;
        pin_kind_d = pin_kind_q;
        light_allow_d = light_allow_q;
        deep_d = deep_q;
        frame_kind_d = frame_kind_q;
        if (addr[8:2] == ACRP_IDX_CHAIN_IDENTITY && wlane[ACRP_LANE_CHAIN_ID])
        begin
            chain_id_d = wword[ACRP_CHAIN_ID_LSB +: 4]; // see R01
        end
        if (addr[8:2] == ACRP_IDX_RESET_POWER && wlane[ACRP_LANE_KEY])
        begin
            key_d = wword[ACRP_KEY_LSB +: 8]; // see R03, R04
        end
        // The old key is compared, so a key and control byte in one write stay locked.
        if (addr[8:2] == ACRP_IDX_RESET_POWER && wlane[ACRP_LANE_CTRL]
            && key_q == ACRP_UNLOCK_VALUE) // see R04, R16
        begin
            supply_off_d = wword[ACRP_SUPPLY_AL_BIT]; // see R05
            input_off_d = wword[ACRP_INPUT_AL_BIT]; // see R06
            pin_kind_d = pin_kind_q | wword[ACRP_PIN_KIND_BIT]; // see R08
            light_allow_d = wword[ACRP_LIGHT_BIT]; // see R09
            deep_d = wword[ACRP_DEEP_BIT]; // see R10
        end
        if (addr[8:2] == ACRP_IDX_SERIAL_INPUT && wlane[ACRP_LANE_FRAME])
        begin
            frame_kind_d = wword[ACRP_FRAME_KIND_LSB +: 2]; // see R11, R14
        end
        // An application reset spares kind, sleep allow and frame kind.
        if (app_class)
        begin
            chain_id_d = ACRP_CHAIN_ID_RESET; // see R12
            key_d = ACRP_KEY_RESET;
            supply_off_d = ACRP_BIT_RESET;
            input_off_d = ACRP_BIT_RESET;
            deep_d = ACRP_BIT_RESET;
        end
    end

    // Light sleep: only when allowed, the select pin stays high and no conversion runs.
    always_comb
    begin
        light_state_d = light_allow_q & conv_sel_s & ~conversion_busy & ~deep_q; // see R09
    end

    // Serial shift engine.
    always_comb
    begin
        frame_d = frame_q;
        sclk_prev_d = sclk_s;
        rst_pin_prev_d = rst_pin_s;
        bit_cnt_d = bit_cnt_q;
        rx_d = rx_q;
        tx_d = tx_q;
        rd_half_d = rd_half_q;
        sdo_d = sdo_q;
        sdo_en_d = sdo_en_q;
        case (frame_q)
            ACRP_FR_IDLE:
            begin
                if (frame_start)
                begin
                    frame_d = ACRP_FR_SHIFT;
                    bit_cnt_d = 6'h00;
                    sdo_en_d = 1'b1;
                    // With CPHA clear the first bit leaves on the select edge.
                    if (!frame_kind_q[0])
                    begin
                        sdo_d = rd_half_q[15];
                        tx_d = {rd_half_q[14:0], 17'h0_0000};
                    end
                    else
                    begin
                        tx_d = {rd_half_q, 16'h0000};
                    end
                end
            end
            ACRP_FR_SHIFT:
            begin
                if (cs_n_s)
                begin
                    frame_d = ACRP_FR_IDLE;
                    sdo_en_d = 1'b0;
                    sdo_d = 1'b0;
                    // A read answer is shifted out during the next frame.
                    if (write_ok && cmd == ACRP_CMD_READ_HALF)
                    begin
                        rd_half_d = addr[1] ? rword[31:16] : rword[15:0];
                    end
                    else if (frame_end)
                    begin
                        rd_half_d = 16'h0000;
                    end
                end
                else
                begin
                    if (capture_edge && bit_cnt_q < ACRP_FRAME_BITS_C)
                    begin
                        rx_d = {rx_q[30:0], sdi_s};
                        bit_cnt_d = bit_cnt_q + 6'h01;
                    end
                    if (launch_edge)
                    begin
                        sdo_d = tx_q[31];
                        tx_d = {tx_q[30:0], 1'b0};
                    end
                end
            end
            default:
            begin
                frame_d = ACRP_FR_IDLE;
            end
        endcase
    end

    // Power-on-class reset clears everything; a pin reset of that class does too.
    always_ff @(posedge ref_clk)
    begin
        if (rst || por_class) // see R07, R12
        begin
            chain_id_q <= ACRP_CHAIN_ID_RESET;
            key_q <= ACRP_KEY_RESET;
            supply_off_q <= ACRP_BIT_RESET;
            input_off_q <= ACRP_BIT_RESET;
            pin_kind_q <= ACRP_BIT_RESET;
            light_allow_q <= ACRP_BIT_RESET;
            deep_q <= ACRP_BIT_RESET;
            frame_kind_q <= ACRP_FRAME_KIND_RESET;
            light_state_q <= 1'b0;
            frame_q <= ACRP_FR_IDLE;
            bit_cnt_q <= 6'h00;
            rx_q <= 32'h0000_0000;
            tx_q <= 32'h0000_0000;
            rd_half_q <= 16'h0000;
            sdo_q <= 1'b0;
            sdo_en_q <= 1'b0;
        end
        else
        begin
            chain_id_q <= chain_id_d;
            key_q <= key_d;
            supply_off_q <= supply_off_d;
            input_off_q <= input_off_d;
            pin_kind_q <= pin_kind_d;
            light_allow_q <= light_allow_d;
            deep_q <= deep_d;
            frame_kind_q <= frame_kind_d;
            light_state_q <= light_state_d;
            frame_q <= frame_d;
            bit_cnt_q <= bit_cnt_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            rd_half_q <= rd_half_d;
            sdo_q <= sdo_d;
            sdo_en_q <= sdo_en_d;
        end
    end

    // Edge history must not be cleared by a pin reset, or the event would repeat.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sclk_prev_q <= 1'b0;
            rst_pin_prev_q <= 1'b1;
        end
        else
        begin
            sclk_prev_q <= sclk_prev_d;
            rst_pin_prev_q <= rst_pin_prev_d;
        end
    end

    assign sdo = sdo_q;
    assign sdo_en = sdo_en_q;
    assign chain_identity = chain_id_q;
    assign supply_alarm_off = supply_off_q;
    assign input_alarm_off = input_off_q;
    assign reset_pin_kind = pin_kind_q;
    assign light_sleep_allow = light_allow_q;
    assign deep_sleep_request = deep_q;
    assign serial_frame_kind = frame_kind_q;
    assign light_sleep_state = light_state_q;
endmodule : acrp_regs

// ===== sim/acrp_host_model.sv
// Purpose: Host side of the serial port, driving frames in any of the four clock modes.
// Assumes: Serial clock half period is four ref_clk cycles, 800 ns per bit.
// Notes: The serial clock stands still at its idle level between frames.
`timescale 1ns/1ns
module acrp_host_model (
    input wire logic ref_clk,
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    logic [1:0] mode = 2'h0;

    // Idle pins at time zero; data line idles at the inverse of its last bit.
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    task automatic half();
        repeat (4) @(posedge ref_clk);
    endtask : half

    // Mode changes only between frames, so the idle level moves with cs_n high.
    task automatic set_mode(input logic [1:0] m);
        @(posedge ref_clk);
        mode = m;
        sclk <= m[1];
        repeat (8) @(posedge ref_clk);
    endtask : set_mode

    // Sends nbits of tx MSB first; sdo is sampled just before the next launch edge.
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = 32'h0000_0000;
        @(posedge ref_clk);
        cs_n <= 1'b0;
        half();
        for (int i = 31; i > 31 - nbits; i--)
        begin
            if (mode[0])
                sclk <= ~sclk;
            sdi <= tx[i];
            half();
            sclk <= ~sclk;
            half();
            rx[i] = sdo;
            if (!mode[0])
                sclk <= ~sclk;
        end
        half();
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (12) @(posedge ref_clk);
    endtask : xfer
endmodule : acrp_host_model

// ===== sim/acrp_regs_properties.sv
// Purpose: Port-level checks for the configuration register slice.
// Assumes: Writes land 4 to 5 ref_clk cycles after cs_n rises.
// Notes: Only sees the ports of acrp_regs.
`timescale 1ns/1ns
module acrp_regs_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic reset_pin_n,
    input wire logic convert_select_pin,
    input wire logic conversion_busy,
    input wire logic sdo,
    input wire logic sdo_en,
    input wire logic [3:0] chain_identity,
    input wire logic supply_alarm_off,
    input wire logic input_alarm_off,
    input wire logic reset_pin_kind,
    input wire logic light_sleep_allow,
    input wire logic deep_sleep_request,
    input wire logic [1:0] serial_frame_kind,
    input wire logic light_sleep_state
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Sleep entry needs all conditions to hold past the synchroniser delay.
    sequence s_sleep_ok;
        (light_sleep_allow && convert_select_pin && !conversion_busy && !deep_sleep_request)[*8];
    endsequence
    sequence s_idle;
        cs_n[*6];
    endsequence

    property p_rst_zero;
        $fell(rst) |-> chain_identity == 4'h0 && !supply_alarm_off && !input_alarm_off
            && !reset_pin_kind && !light_sleep_allow && !deep_sleep_request
            && serial_frame_kind == 2'h0 && !light_sleep_state;
    endproperty
    property p_kind_sticky;
        $fell(reset_pin_kind) |-> $past(rst);
    endproperty
    property p_frame_quiet;
        $changed(serial_frame_kind) && serial_frame_kind != 2'h0 |-> $past(cs_n, 3);
    endproperty
    property p_chain_quiet;
        $changed(chain_identity) && chain_identity != 4'h0 |-> $past(cs_n, 3);
    endproperty
    property p_idle_quiet;
        s_idle |-> !sdo_en && !sdo;
    endproperty
    property p_frame_drive;
        (!cs_n)[*6] |-> sdo_en;
    endproperty
    property p_sleep_entry;
        s_sleep_ok |-> light_sleep_state;
    endproperty
    property p_sleep_allow;
        (!light_sleep_allow)[*2] |-> !light_sleep_state;
    endproperty
    property p_sleep_select;
        (!convert_select_pin)[*6] |-> !light_sleep_state;
    endproperty
    property p_sleep_deep;
        deep_sleep_request[*2] |-> !light_sleep_state;
    endproperty
    property p_sleep_busy;
        conversion_busy[*2] |-> !light_sleep_state;
    endproperty

    a_rst_zero: assert property (p_rst_zero) else $error("fields not zero after reset");
    a_kind_sticky: assert property (p_kind_sticky) else $error("pin kind cleared");
    a_frame_quiet: assert property (p_frame_quiet) else $error("frame kind mid-frame");
    a_chain_quiet: assert property (p_chain_quiet) else $error("chain id mid-frame");
    a_idle_quiet: assert property (p_idle_quiet) else $error("sdo active outside frame");
    a_frame_drive: assert property (p_frame_drive) else $error("sdo idle in frame");
    a_sleep_entry: assert property (p_sleep_entry) else $error("light sleep missed");
    a_sleep_allow: assert property (p_sleep_allow) else $error("sleep not allowed");
    a_sleep_select: assert property (p_sleep_select) else $error("sleep with select low");
    a_sleep_deep: assert property (p_sleep_deep) else $error("sleep in power-down");
    a_sleep_busy: assert property (p_sleep_busy) else $error("sleep while busy");
endmodule : acrp_regs_properties

bind acrp_regs acrp_regs_properties acrp_regs_properties_i (
    .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .reset_pin_n(reset_pin_n), .convert_select_pin(convert_select_pin),
    .conversion_busy(conversion_busy), .sdo(sdo), .sdo_en(sdo_en),
    .chain_identity(chain_identity), .supply_alarm_off(supply_alarm_off),
    .input_alarm_off(input_alarm_off), .reset_pin_kind(reset_pin_kind),
    .light_sleep_allow(light_sleep_allow), .deep_sleep_request(deep_sleep_request),
    .serial_frame_kind(serial_frame_kind), .light_sleep_state(light_sleep_state)
);

// ===== sim/test_acrp_regs.sv
// Purpose: Self-checking bench for the configuration register slice.
// Assumes: Host model frames of 32 bits, read answers in the next frame.
// Notes: The 16-clock frame checks that short writes are dropped.
`timescale 1ns/1ns
module test_acrp_regs
    import acrp_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic convert_select_pin = 1'b0;
    logic conversion_busy = 1'b0;
    logic sclk, cs_n, sdi, sdo, sdo_en, light_sleep_state;
    logic supply_alarm_off, input_alarm_off, reset_pin_kind;
    logic light_sleep_allow, deep_sleep_request;
    logic [3:0] chain_identity;
    logic [1:0] serial_frame_kind;
    logic [5:0] ctl;
    logic [31:0] rx;
    int n_mismatch = 0;
    int compares = 0;

    // Clock of 100 ns period.
    always #50 ref_clk = ~ref_clk;

    acrp_host_model acrp_host_model_i (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo));
    acrp_regs acrp_regs_i (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .reset_pin_n(reset_pin_n), .convert_select_pin(convert_select_pin),
        .conversion_busy(conversion_busy), .sdo(sdo), .sdo_en(sdo_en),
        .chain_identity(chain_identity), .supply_alarm_off(supply_alarm_off),
        .input_alarm_off(input_alarm_off), .reset_pin_kind(reset_pin_kind),
        .light_sleep_allow(light_sleep_allow), .deep_sleep_request(deep_sleep_request),
        .serial_frame_kind(serial_frame_kind), .light_sleep_state(light_sleep_state));
    // Control bits packed at their register positions; bit 3 is reserved and reads zero.
    assign ctl = {supply_alarm_off, input_alarm_off, 1'b0, reset_pin_kind, light_sleep_allow,
        deep_sleep_request};

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [6:0] cmd, input logic [8:0] addr, input logic [15:0] d);
        logic [31:0] r;
        acrp_host_model_i.xfer({cmd, addr, d}, 32, r);
    endtask : wr

    // A read answers in the first half of the following frame.
    task automatic rd(input logic [8:0] addr, input logic [15:0] exp);
        logic [31:0] r;
        acrp_host_model_i.xfer({ACRP_CMD_READ_HALF, addr, 16'h0000}, 32, r);
        acrp_host_model_i.xfer({ACRP_CMD_NOP, 9'h000, 16'h0000}, 32, r);
        check({16'h0000, r[31:16]}, {16'h0000, exp});
    endtask : rd

    task automatic print_verdict();
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // Watchdog well beyond the roughly 1 ms the sequence needs.
    initial
    begin
        #6000000;
        n_mismatch++;
        print_verdict();
    end

    // Main sequence of register traffic.
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check({26'h0, ctl}, 32'h0);
        rd(ACRP_OFS_CHAIN_IDENTITY + 9'h002, 16'h0000);
        rd(ACRP_OFS_SERIAL_INPUT, 16'h0000);
        wr(ACRP_CMD_WRITE_BYTE, 9'h002, 16'h0005);
        check({28'h0, chain_identity}, 32'h5);
        wr(ACRP_CMD_WRITE_HALF, 9'h002, 16'hFFFF);
        rd(9'h002, 16'h000F);
        // The unmapped write leaves a chain id write command in the receive shifter.
        wr(ACRP_CMD_WRITE_BYTE, 9'h00C, {ACRP_CMD_WRITE_BYTE, 9'h002});
        acrp_host_model_i.xfer({16'h0003, 16'h0000}, 16, rx);
        check({28'h0, chain_identity}, 32'hF);
        wr(ACRP_CMD_WRITE_BYTE, 9'h004, 16'h003F);
        check({26'h0, ctl}, 32'h0);
        wr(ACRP_CMD_WRITE_BYTE, 9'h005, 16'h0069);
        wr(ACRP_CMD_WRITE_BYTE, 9'h004, 16'h00FF);
        check({26'h0, ctl}, 32'h37);
        rd(ACRP_OFS_RESET_POWER, 16'h6937);
        convert_select_pin <= 1'b1;
        repeat (12) @(posedge ref_clk);
        check({31'h0, light_sleep_state}, 32'h0);
        wr(ACRP_CMD_WRITE_BYTE, 9'h004, 16'h0002);
        check({26'h0, ctl}, 32'h06);
        repeat (12) @(posedge ref_clk);
        check({31'h0, light_sleep_state}, 32'h1);
        conversion_busy <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check({31'h0, light_sleep_state}, 32'h0);
        conversion_busy <= 1'b0;
        convert_select_pin <= 1'b0;
        // Each mode is entered with a mode 0 write and left with a write in that mode.
        for (int m = 1; m < 4; m++)
        begin
            wr(ACRP_CMD_WRITE_BYTE, ACRP_OFS_SERIAL_INPUT, 16'(m));
            acrp_host_model_i.set_mode(2'(m));
            rd(ACRP_OFS_SERIAL_INPUT, 16'(m));
            check({30'h0, serial_frame_kind}, 32'(m));
            wr(ACRP_CMD_WRITE_BYTE, ACRP_OFS_SERIAL_INPUT, 16'h0000);
            acrp_host_model_i.set_mode(2'h0);
        end
        wr(ACRP_CMD_WRITE_BYTE, ACRP_OFS_SERIAL_INPUT, 16'h0001);
        acrp_host_model_i.set_mode(2'h1);
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        reset_pin_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check({28'h0, chain_identity}, 32'h0);
        check({24'h0, ctl, serial_frame_kind}, 32'h19);
        rd(ACRP_OFS_RESET_POWER, 16'h0006);
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        acrp_host_model_i.set_mode(2'h0);
        check({24'h0, ctl, serial_frame_kind}, 32'h0);
        // With the pin kind clear, the pin reset also clears the sleep allow bit.
        wr(ACRP_CMD_WRITE_BYTE, 9'h002, 16'h000A);
        wr(ACRP_CMD_WRITE_BYTE, 9'h005, 16'h0069);
        wr(ACRP_CMD_WRITE_BYTE, 9'h004, 16'h0002);
        check({22'h0, chain_identity, ctl}, 32'h282);
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        reset_pin_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check({22'h0, chain_identity, ctl}, 32'h0);
        rd(9'h00C, 16'h0000);
        print_verdict();
    end
endmodule : test_acrp_regs
